// ### verilog/wheel_touch_pkg.sv
// Constants, register map and carrier types for the wheel touch position block.
//
// Functional notes
// - Release debounce bits 3:2 select 1-4 samples.
// - Touch debounce bits 1:0 select 1-4 samples.
// - Hold timeout counts seconds, zero disables.
// - Timeout forces release until real finger release.
// - Touch margin equals code times four.
// - Scale is high byte then low byte.
// - Ticks at or above average limit hold averaging.
// - Three sensors at average limit request compensation.
// - Negative limit magnitude equals code times four.
// - Negative sample count reaching maximum requests compensation.
// - Fast position change flags clockwise or counter-clockwise.
// - Angle shift adds code/256 turn clockwise.
// - Weight sums excess ticks above sensor limits.
// - Zero weight means wheel released.
// - Weight above margin starts touch debounce.
// - Without release debounce, first zero weight releases.
// - Angle is scale/32 times weighted centre.
// - Angle is split into high and low bytes.
// - Angle ranges zero to scale/32 times sensors.
package wheel_touch_pkg;

   localparam int unsigned SENSORS = 6;

   localparam logic [7:0] ADDR_DEBOUNCE_CONFIG   = 8'h27;
   localparam logic [7:0] ADDR_HOLD_TIMEOUT      = 8'h28;
   localparam logic [7:0] ADDR_TOUCH_MARGIN      = 8'h29;
   localparam logic [7:0] ADDR_SCALE_HIGH        = 8'h2B;
   localparam logic [7:0] ADDR_SCALE_LOW         = 8'h2C;
   localparam logic [7:0] ADDR_AVERAGE_LIMIT     = 8'h2D;
   localparam logic [7:0] ADDR_NEGATIVE_LIMIT    = 8'h2E;
   localparam logic [7:0] ADDR_NEGATIVE_COUNT    = 8'h2F;
   localparam logic [7:0] ADDR_ROTATION_LIMIT    = 8'h30;
   localparam logic [7:0] ADDR_ANGLE_SHIFT       = 8'h31;

   localparam logic [7:0] RST_DEBOUNCE_CONFIG    = 8'h00;
   localparam logic [7:0] RST_HOLD_TIMEOUT       = 8'h00;
   localparam logic [7:0] RST_TOUCH_MARGIN       = 8'h03;
   localparam logic [7:0] RST_SCALE_HIGH         = 8'h01;
   localparam logic [7:0] RST_SCALE_LOW          = 8'h40;
   localparam logic [7:0] RST_AVERAGE_LIMIT      = 8'h50;
   localparam logic [7:0] RST_NEGATIVE_LIMIT     = 8'h50;
   localparam logic [7:0] RST_NEGATIVE_COUNT     = 8'h01;
   localparam logic [7:0] RST_ROTATION_LIMIT     = 8'h02;
   localparam logic [7:0] RST_ANGLE_SHIFT        = 8'h00;

   localparam int unsigned TOUCH_DEB_LSB   = 0;
   localparam int unsigned RELEASE_DEB_LSB = 2;
   localparam int unsigned LIMIT_SHIFT     = 2;
   localparam int unsigned SCALE_DIV_SHIFT = 5;
   localparam int unsigned TURN_SHIFT      = 8;
   localparam int unsigned PERCENT_FULL    = 100;
   localparam int unsigned AVG_COMP_COUNT  = 3;

   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned SECOND_NS     = 1000000000;
   localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic signed [15:0] diff;
      logic        [15:0] limit;
   } sensor_sample_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      ST_RELEASED = 2'b00,
      ST_TOUCHED  = 2'b01,
      ST_HELD     = 2'b11
   } wheel_state_t;

endpackage

// ### verilog/wheel_divider.sv
// Sequential restoring divider for the centre-of-gravity angle.
module wheel_divider
(
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   input  wire logic        start_i,
   input  wire logic [39:0] dividend_i,
   input  wire logic [23:0] divisor_i,
   output logic             done_o,
   output logic [15:0]      quotient_o
);

   logic [39:0] quo_q;
   logic [24:0] rem_q;
   logic [5:0]  cnt_q;
   logic [23:0] den_q;
   logic        busy_q;
   logic [24:0] trial;

   assign trial = {rem_q[23:0], quo_q[39]} - {1'b0, den_q};

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         quo_q  <= 40'h00_0000_0000;
         rem_q  <= 25'h000_0000;
         cnt_q  <= 6'h00;
         den_q  <= 24'h00_0000;
         busy_q <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i && !busy_q)
         begin
            quo_q  <= dividend_i;
            rem_q  <= 25'h000_0000;
            den_q  <= divisor_i;
            cnt_q  <= 6'h28;
            busy_q <= 1'b1;
         end
         else if (busy_q)
         begin
            if (!trial[24])
            begin
               rem_q <= trial;
               quo_q <= {quo_q[38:0], 1'b1};
            end
            else
            begin
               rem_q <= {rem_q[23:0], quo_q[39]};
               quo_q <= {quo_q[38:0], 1'b0};
            end
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01)
            begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end

   assign quotient_o = (|quo_q[39:16]) ? 16'hFFFF : quo_q[15:0];

endmodule

// ### verilog/wheel_touch_position.sv
// Wheel pressure, touch decision, centre-of-gravity angle and rotation detection.
module wheel_touch_position #(
   parameter int unsigned SECOND_CYCLES = wheel_touch_pkg::SECOND_CYCLES
)
(
   input  wire logic                           ref_clk_i,
   input  wire logic                           srst_i,
   input  wire logic                           scan_tick_i,
   input  wire wheel_touch_pkg::sensor_sample_t [5:0] sample_i,
   input  wire wheel_touch_pkg::reg_req_t      reg_req_i,
   output logic [7:0]                          reg_rdata_o,
   output logic [15:0]                         wheel_finger_weight_o,
   output logic [7:0]                          wheel_angle_high_o,
   output logic [7:0]                          wheel_angle_low_o,
   output logic                                wheel_touched_o,
   output logic                                rotate_cw_o,
   output logic                                rotate_ccw_o,
   output logic                                average_hold_o,
   output logic                                comp_request_o
);

   logic [7:0]   cfg_q, hold_to_q, margin_q, scale_hi_q, scale_lo_q;
   logic [7:0]   avg_lim_q, neg_lim_q, neg_max_q, rot_lim_q, shift_q;
   logic [16:0]  excess [6];
   logic [5:0]   over_avg, under_neg;
   logic [19:0]  pressure_c;
   logic [22:0]  weighted_c;
   logic [2:0]   avg_cnt_c;
   logic [15:0]  scale_c;
   logic [15:0]  ceiling_c;
   logic [15:0]  weight_q;
   wheel_touch_pkg::wheel_state_t state_q;
   logic [1:0]   touch_cnt_q, rel_cnt_q;
   logic [25:0]  sec_cnt_q;
   logic         sec_tick;
   logic [7:0]   hold_sec_q;
   logic [7:0]   neg_cnt_q;
   logic         div_start_q, div_done;
   logic [15:0]  div_quo;
   logic [15:0]  angle_q, prev_angle_q;
   logic         prev_valid_q;
   logic [16:0]  angle_sum;
   logic [15:0]  angle_new;
   logic signed [17:0] delta;
   logic [16:0]  delta_abs;
   logic         press_zero, press_over;

   // Register port: byte writes and registered byte reads.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         cfg_q      <= wheel_touch_pkg::RST_DEBOUNCE_CONFIG;
         hold_to_q  <= wheel_touch_pkg::RST_HOLD_TIMEOUT;
         margin_q   <= wheel_touch_pkg::RST_TOUCH_MARGIN;
         scale_hi_q <= wheel_touch_pkg::RST_SCALE_HIGH;
         scale_lo_q <= wheel_touch_pkg::RST_SCALE_LOW;
         avg_lim_q  <= wheel_touch_pkg::RST_AVERAGE_LIMIT;
         neg_lim_q  <= wheel_touch_pkg::RST_NEGATIVE_LIMIT;
         neg_max_q  <= wheel_touch_pkg::RST_NEGATIVE_COUNT;
         rot_lim_q  <= wheel_touch_pkg::RST_ROTATION_LIMIT;
         shift_q    <= wheel_touch_pkg::RST_ANGLE_SHIFT;
      end
      else if (reg_req_i.wr)
      begin
         unique case (reg_req_i.addr)
            wheel_touch_pkg::ADDR_DEBOUNCE_CONFIG: cfg_q <= {4'h0, reg_req_i.wdata[3:0]};
            wheel_touch_pkg::ADDR_HOLD_TIMEOUT:    hold_to_q  <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_TOUCH_MARGIN:    margin_q   <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_SCALE_HIGH:      scale_hi_q <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_SCALE_LOW:       scale_lo_q <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_AVERAGE_LIMIT:   avg_lim_q  <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_NEGATIVE_LIMIT:  neg_lim_q  <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_NEGATIVE_COUNT:  neg_max_q  <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_ROTATION_LIMIT:  rot_lim_q  <= reg_req_i.wdata;
            wheel_touch_pkg::ADDR_ANGLE_SHIFT:     shift_q    <= reg_req_i.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         reg_rdata_o <= 8'h00;
      else if (reg_req_i.rd)
      begin
         unique case (reg_req_i.addr)
            wheel_touch_pkg::ADDR_DEBOUNCE_CONFIG: reg_rdata_o <= cfg_q;
            wheel_touch_pkg::ADDR_HOLD_TIMEOUT:    reg_rdata_o <= hold_to_q;
            wheel_touch_pkg::ADDR_TOUCH_MARGIN:    reg_rdata_o <= margin_q;
            wheel_touch_pkg::ADDR_SCALE_HIGH:      reg_rdata_o <= scale_hi_q;
            wheel_touch_pkg::ADDR_SCALE_LOW:       reg_rdata_o <= scale_lo_q;
            wheel_touch_pkg::ADDR_AVERAGE_LIMIT:   reg_rdata_o <= avg_lim_q;
            wheel_touch_pkg::ADDR_NEGATIVE_LIMIT:  reg_rdata_o <= neg_lim_q;
            wheel_touch_pkg::ADDR_NEGATIVE_COUNT:  reg_rdata_o <= neg_max_q;
            wheel_touch_pkg::ADDR_ROTATION_LIMIT:  reg_rdata_o <= rot_lim_q;
            wheel_touch_pkg::ADDR_ANGLE_SHIFT:     reg_rdata_o <= shift_q;
            default:                               reg_rdata_o <= 8'h00;
         endcase
      end
   end

   assign scale_c = {scale_hi_q, scale_lo_q};

   // Per-sensor excess over its limit and the limit comparisons.
   for (genvar i = 0; i < 6; i++)
   begin : g_sensor
      logic signed [17:0] d_ext, l_ext, a_lim, n_lim;
      assign d_ext = 18'(sample_i[i].diff);
      assign l_ext = {2'b00, sample_i[i].limit};
      assign a_lim = {8'h00, avg_lim_q, 2'b00};
      assign n_lim = -{8'h00, neg_lim_q, 2'b00};
      assign excess[i] = (d_ext > l_ext) ? 17'(d_ext - l_ext) : 17'h0_0000;
      assign over_avg[i]  = (d_ext >= a_lim);
      assign under_neg[i] = (d_ext < n_lim);
   end

   always_comb
   begin
      pressure_c = 20'h0_0000;
      weighted_c = 23'h00_0000;
      avg_cnt_c  = 3'h0;
      for (int k = 0; k < 6; k++)
      begin
         pressure_c = pressure_c + 20'(excess[k]);
         weighted_c = weighted_c + 23'(excess[k]) * 23'(k);
         avg_cnt_c  = avg_cnt_c + 3'(over_avg[k]);
      end
   end

   assign ceiling_c  = 16'((32'(scale_c) * 32'(6)) >> wheel_touch_pkg::SCALE_DIV_SHIFT);
   assign press_zero = (pressure_c == 20'h0_0000);
   assign press_over = (pressure_c > {10'h000, margin_q, 2'b00});

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         weight_q <= 16'h0000;
      else if (scan_tick_i)
         weight_q <= (|pressure_c[19:16]) ? 16'hFFFF : pressure_c[15:0];
   end

   // One-second enable for the hold timeout, restarted at each touch so the first second is whole.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i || sec_tick || state_q != wheel_touch_pkg::ST_TOUCHED)
         sec_cnt_q <= 26'h000_0000;
      else
         sec_cnt_q <= sec_cnt_q + 26'h000_0001;
   end
   assign sec_tick = (sec_cnt_q == 26'(SECOND_CYCLES - 1));

   // Touch decision with debounce and hold timeout.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         state_q     <= wheel_touch_pkg::ST_RELEASED;
         touch_cnt_q <= 2'h0;
         rel_cnt_q   <= 2'h0;
         hold_sec_q  <= 8'h00;
      end
      else
      begin
         if (state_q == wheel_touch_pkg::ST_TOUCHED && sec_tick)
            hold_sec_q <= hold_sec_q + 8'h01;
         unique case (state_q)
            wheel_touch_pkg::ST_RELEASED:
            begin
               hold_sec_q <= 8'h00;
               if (scan_tick_i)
               begin
                  if (!press_over)
                     touch_cnt_q <= 2'h0;
                  else if (touch_cnt_q == cfg_q[1:0])
                  begin
                     touch_cnt_q <= 2'h0;
                     rel_cnt_q   <= 2'h0;
                     state_q     <= wheel_touch_pkg::ST_TOUCHED;
                  end
                  else
                     touch_cnt_q <= touch_cnt_q + 2'h1;
               end
            end
            wheel_touch_pkg::ST_TOUCHED:
            begin
               if (sec_tick && hold_to_q != 8'h00 && hold_sec_q + 8'h01 >= hold_to_q)
                  state_q <= wheel_touch_pkg::ST_HELD;
               else if (scan_tick_i)
               begin
                  if (!press_zero)
                     rel_cnt_q <= 2'h0;
                  else if (rel_cnt_q == cfg_q[3:2])
                  begin
                     rel_cnt_q <= 2'h0;
                     state_q   <= wheel_touch_pkg::ST_RELEASED;
                  end
                  else
                     rel_cnt_q <= rel_cnt_q + 2'h1;
               end
            end
            wheel_touch_pkg::ST_HELD:
            begin
               if (scan_tick_i && press_zero)
                  state_q <= wheel_touch_pkg::ST_RELEASED;
            end
            default: state_q <= wheel_touch_pkg::ST_RELEASED;
         endcase
      end
   end

   assign wheel_touched_o = (state_q == wheel_touch_pkg::ST_TOUCHED);

   // Averaging hold and offset compensation requests.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         average_hold_o <= 1'b0;
         comp_request_o <= 1'b0;
         neg_cnt_q      <= 8'h00;
      end
      else
      begin
         comp_request_o <= 1'b0;
         if (scan_tick_i)
         begin
            average_hold_o <= |over_avg;
            if (avg_cnt_c >= 3'(wheel_touch_pkg::AVG_COMP_COUNT))
               comp_request_o <= 1'b1;
            if (!(|under_neg))
               neg_cnt_q <= 8'h00;
            else if (neg_cnt_q + 8'h01 >= neg_max_q)
            begin
               neg_cnt_q      <= 8'h00;
               comp_request_o <= 1'b1;
            end
            else
               neg_cnt_q <= neg_cnt_q + 8'h01;
         end
      end
   end

   // Centre of gravity: scale times weighted sum over 32 times pressure.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         div_start_q <= 1'b0;
      else
         div_start_q <= scan_tick_i && !press_zero;
   end

   logic [39:0] dividend_q;
   logic [23:0] divisor_q;
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         dividend_q <= 40'h00_0000_0000;
         divisor_q  <= 24'h00_0000;
      end
      else if (scan_tick_i)
      begin
         dividend_q <= 40'(weighted_c) * 40'(scale_c);
         divisor_q  <= {pressure_c[18:0], 5'h00};
      end
   end

   wheel_divider u_divider (
      .ref_clk_i  (ref_clk_i),
      .srst_i     (srst_i),
      .start_i    (div_start_q),
      .dividend_i (dividend_q),
      .divisor_i  (divisor_q),
      .done_o     (div_done),
      .quotient_o (div_quo)
   );

   assign angle_sum = 17'(div_quo) +
                      17'((32'(ceiling_c) * 32'(shift_q)) >> wheel_touch_pkg::TURN_SHIFT);
   assign angle_new = (angle_sum >= 17'(ceiling_c)) ? 16'(angle_sum - 17'(ceiling_c))
                                                    : angle_sum[15:0];

   always_comb
   begin
      delta = 18'(angle_new) - 18'(prev_angle_q);
      if (delta > $signed(18'(ceiling_c >> 1)))
         delta = delta - 18'(ceiling_c);
      else if (delta < -$signed(18'(ceiling_c >> 1)))
         delta = delta + 18'(ceiling_c);
      delta_abs = delta[17] ? 17'(-delta) : 17'(delta);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         angle_q      <= 16'h0000;
         prev_angle_q <= 16'h0000;
         prev_valid_q <= 1'b0;
         rotate_cw_o  <= 1'b0;
         rotate_ccw_o <= 1'b0;
      end
      else if (!wheel_touched_o)
      begin
         prev_valid_q <= 1'b0;
         rotate_cw_o  <= 1'b0;
         rotate_ccw_o <= 1'b0;
      end
      else if (div_done)
      begin
         angle_q      <= angle_new;
         prev_angle_q <= angle_new;
         prev_valid_q <= 1'b1;
         rotate_cw_o  <= prev_valid_q && !delta[17] && (32'(delta_abs) * 32'(100) >
                         32'(ceiling_c) * 32'(rot_lim_q));
         rotate_ccw_o <= prev_valid_q && delta[17] && (32'(delta_abs) * 32'(100) >
                         32'(ceiling_c) * 32'(rot_lim_q));
      end
   end

   assign wheel_angle_high_o    = angle_q[15:8];
   assign wheel_angle_low_o     = angle_q[7:0];
   assign wheel_finger_weight_o = weight_q;

   AST_RELEASE_ZERO: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (scan_tick_i && press_zero && cfg_q[3:2] == 2'h0 &&
       state_q == wheel_touch_pkg::ST_TOUCHED && !sec_tick)
      |=> state_q == wheel_touch_pkg::ST_RELEASED)
      else $error("Release not taken on first zero weight.");

   AST_NO_TOUCH_BELOW_MARGIN: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state_q == wheel_touch_pkg::ST_RELEASED && scan_tick_i && !press_over)
      |=> state_q == wheel_touch_pkg::ST_RELEASED)
      else $error("Touch declared with weight at or below margin.");

   AST_TOUCH_IMMEDIATE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state_q == wheel_touch_pkg::ST_RELEASED && scan_tick_i && press_over &&
       cfg_q[1:0] == 2'h0) |=> wheel_touched_o)
      else $error("Touch without debounce not immediate.");

   AST_RELEASE_DEBOUNCED: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state_q == wheel_touch_pkg::ST_TOUCHED && scan_tick_i && rel_cnt_q == 2'h0 &&
       cfg_q[3:2] != 2'h0 && !sec_tick) |=> state_q == wheel_touch_pkg::ST_TOUCHED)
      else $error("Release taken before debounce count.");

   AST_HOLD_TIMEOUT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state_q == wheel_touch_pkg::ST_TOUCHED && sec_tick && hold_to_q != 8'h00 &&
       hold_sec_q + 8'h01 == hold_to_q) |=> !wheel_touched_o [*2])
      else $error("Hold timeout did not force release.");

   AST_HELD_UNTIL_ZERO: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state_q == wheel_touch_pkg::ST_HELD && !(scan_tick_i && press_zero))
      |=> state_q == wheel_touch_pkg::ST_HELD)
      else $error("Held state left without real release.");

   AST_AVG_COMP: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (scan_tick_i && avg_cnt_c >= 3'h3) |=> comp_request_o)
      else $error("Compensation not requested for three sensors.");

   AST_WEIGHT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (scan_tick_i && pressure_c[19:16] == 4'h0) |=> weight_q == $past(pressure_c[15:0]))
      else $error("Finger weight not captured.");

   AST_ANGLE_FROZEN: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !wheel_touched_o |=> $stable(angle_q))
      else $error("Angle changed while released.");

   AST_ANGLE_RANGE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (div_done && wheel_touched_o && div_quo < ceiling_c) |=> angle_q < ceiling_c)
      else $error("Angle beyond ceiling.");

endmodule

// ### testbench/sensor_front_model.sv
// Sensor front end model that issues the periodic scan tick and samples registered on every clock.
module sensor_front_model #(
   parameter int unsigned PERIOD = 60
)
(
   input  wire logic                                  ref_clk_i,
   input  wire logic                                  srst_i,
   input  wire wheel_touch_pkg::sensor_sample_t [5:0] next_i,
   output logic                                       scan_tick_o,
   output wheel_touch_pkg::sensor_sample_t [5:0]      sample_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned cnt_q;
   always_ff @(posedge ref_clk_i)
   begin
      cnt_q       <= (srst_i || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      scan_tick_o <= !srst_i && cnt_q == PERIOD - 1;
      sample_o    <= next_i;
   end
endmodule

// ### testbench/wheel_touch_position_test.sv
// Self-checking bench for the wheel touch position block.
module wheel_touch_position_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic                                  ref_clk_i, srst_i, tick, touched, cw, ccw, hold, comp;
   logic                                  comp_seen;
   logic [7:0]                            rdata, ah, al, wv;
   logic [15:0]                           weight;
   wheel_touch_pkg::sensor_sample_t [5:0] next, sample;
   wheel_touch_pkg::reg_req_t             req;
   int                                    bad_count, cmp_count, seed;
   logic [7:0] addrs [11] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F,
                              8'h30, 8'h31};
   logic [7:0] dflt [11]  = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h40, 8'h50, 8'h50, 8'h01,
                              8'h02, 8'h00};

   sensor_front_model i_front (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .next_i(next),
                               .scan_tick_o(tick), .sample_o(sample));
   wheel_touch_position #(.SECOND_CYCLES(200)) i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .scan_tick_i(tick), .sample_i(sample), .reg_req_i(req), .reg_rdata_o(rdata),
      .wheel_finger_weight_o(weight), .wheel_angle_high_o(ah), .wheel_angle_low_o(al),
      .wheel_touched_o(touched), .rotate_cw_o(cw), .rotate_ccw_o(ccw),
      .average_hold_o(hold), .comp_request_o(comp));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk_i);
      req <= '0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk_i);
      req <= '0;
      @(negedge ref_clk_i);
      check("reg_rdata_o", {24'h0, rdata}, {24'h0, exp});
   endtask

   // Waits for one scan and its angle result, noting any compensation pulse.
   task automatic scan();
      comp_seen = 1'b0;
      @(negedge ref_clk_i iff tick);
      repeat (48)
      begin
         @(negedge ref_clk_i);
         comp_seen |= comp;
      end
   endtask

   task automatic put(input int k, input int e);
      next = '0;
      next[k].diff = e[15:0];
   endtask

   task automatic chk_out(input logic t, input logic [1:0] rot, input logic [15:0] ang);
      check("wheel_touched_o", {31'h0, touched}, {31'h0, t});
      check("rotate", {30'h0, cw, ccw}, {30'h0, rot});
      check("wheel_angle", {16'h0, ah, al}, {16'h0, ang});
   endtask

   function automatic logic [15:0] exp_weight(input wheel_touch_pkg::sensor_sample_t [5:0] s);
      int sum;
      sum = 0;
      for (int i = 0; i < 6; i++)
         if (s[i].diff > $signed({1'b0, s[i].limit}))
            sum += s[i].diff - int'(s[i].limit);
      return (sum > 65535) ? 16'hFFFF : sum[15:0];
   endfunction

   initial
   begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      bad_count++;
      end_sim();
   end

   initial
   begin
      seed = 32'h44912a16;
      srst_i = 1'b1;
      req = '0;
      next = '0;
      repeat (10) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      for (int i = 0; i < 11; i++)
         rd_chk(addrs[i], dflt[i]);
      reg_wr(8'h2A, 8'hFF);
      rd_chk(8'h2A, 8'h00);
      reg_wr(8'h27, 8'hFF);
      rd_chk(8'h27, 8'h0F);
      reg_wr(8'h27, 8'h05);
      scan();
      check("weight", {16'h0, weight}, 32'h0);
      put(2, 100);
      scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h0);
      scan();
      check("weight", {16'h0, weight}, 32'd100);
      chk_out(1'b1, 2'b00, 16'd20);
      put(1, 100);
      scan();
      chk_out(1'b1, 2'b01, 16'd10);
      put(3, 100);
      scan();
      chk_out(1'b1, 2'b10, 16'd30);
      reg_wr(8'h31, 8'h40);
      scan();
      chk_out(1'b1, 2'b10, 16'd45);
      put(5, 100);
      scan();
      chk_out(1'b1, 2'b10, 16'd5);
      reg_wr(8'h31, 8'h00);
      put(0, 0);
      scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h1);
      scan();
      chk_out(1'b0, 2'b00, 16'd5);
      reg_wr(8'h27, 8'h00);
      put(4, 12);
      scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h0);
      put(4, 13);
      scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h1);
      put(4, 0);
      scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h0);
      reg_wr(8'h28, 8'h01);
      put(1, 100);
      repeat (2) scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h1);
      repeat (4) scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h0);
      put(1, 0);
      scan();
      put(1, 100);
      scan();
      check("wheel_touched_o", {31'h0, touched}, 32'h1);
      reg_wr(8'h28, 8'h00);
      put(0, 320);
      scan();
      check("average_hold_o", {30'h0, hold, comp_seen}, 32'h2);
      put(0, 319);
      scan();
      check("average_hold_o", {31'h0, hold}, 32'h0);
      for (int i = 0; i < 3; i++)
         next[i].diff = 16'd320;
      scan();
      check("comp_request_o", {31'h0, comp_seen}, 32'h1);
      put(0, -321);
      scan();
      check("comp_request_o", {31'h0, comp_seen}, 32'h1);
      put(0, -320);
      scan();
      check("comp_request_o", {31'h0, comp_seen}, 32'h0);
      reg_wr(8'h2F, 8'h02);
      put(0, -400);
      scan();
      check("comp_request_o", {31'h0, comp_seen}, 32'h0);
      scan();
      check("comp_request_o", {31'h0, comp_seen}, 32'h1);
      repeat (20)
      begin
         for (int i = 0; i < 6; i++)
            next[i] = '{16'($random(seed) % 600), 16'($unsigned($random(seed)) % 300)};
         scan();
         check("weight", {16'h0, weight}, {16'h0, exp_weight(next)});
      end
      for (int i = 1; i < 11; i++)
      begin
         wv = 8'($random(seed));
         reg_wr(addrs[i], wv);
         rd_chk(addrs[i], (i == 3) ? 8'h00 : wv);
      end
      end_sim();
   end
endmodule
